// >>> rtl/cid_core.sv
// Instruction decode and execute core for a subset of byte instructions.
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.svh"

// Function
// - increment_skip_nonzero adds one to the register, flags untouched.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - A nonzero increment result turns the prefetched word into a NOP.
// - A skipped two-word instruction costs one further NOP cycle.
// - Bank bit 0 uses the access bank, 1 uses the bank select register.
// - Bank bit 0, extended set on, address up to 95: indexed offset mode.
// - or_literal_into_accumulator ORs a literal into W, sets N and Z.
// - load_pointer_literal: two words, high part first, low part second.
// - copy_file_register copies a register to its target, sets N and Z.
// - copy_file_to_file moves between two 12-bit addresses, no flags.
// - copy_file_to_file may take W as its source or destination.
// - load_bank_literal forces the upper four bank select bits to zero.
// - load_accumulator_literal loads the literal in one cycle, no flags.
module cid_core #(
   parameter int AXI_ADDR_W = 6
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_valid,
   output logic fetch_ready,
   output logic [11:0] mem_addr,
   output logic mem_rd_en,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr_en,
   output logic [7:0] mem_wdata,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   initial begin
      if (AXI_ADDR_W < 6) begin
         $error("cid_core: AXI_ADDR_W must be at least 6");
      end
   end

   cid_pkg::cid_phase_e phase_reg;
   cid_pkg::cid_op_e op_reg;
   cid_pkg::cid_op_e dec_op;
   logic [15:0] ir_reg;
   logic [15:0] lo_reg;
   logic second_reg;
   logic skip_reg;
   logic src_w_reg;
   logic dest_w_reg;
   logic [7:0] w_reg;
   logic [7:0] bsr_reg;
   logic [11:0] ptr_reg [`CID_PTR_COUNT];
   logic neg_reg;
   logic zero_reg;
   logic [7:0] hold_reg;
   logic [7:0] res_reg;
   logic [7:0] res_next;
   logic ext_reg;
   logic halt_reg;
   logic take;
   logic [11:0] eff_addr;
   logic [7:0] operand;
   logic aw_have_reg;
   logic w_have_reg;
   logic [AXI_ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] rd_mux;
   logic rd_hit;

   function automatic logic two_word(input logic [15:0] word);
      two_word = (word[15:12] == `CID_OP4_COPY_FILE_TO_FILE) ||
                 (word[15:10] == `CID_OP6_TWO_WORD);
   endfunction

   assign take = (phase_reg == cid_pkg::CID_Q1) && fetch_valid && fetch_ready;
   assign operand = src_w_reg ? w_reg : mem_rdata;

   // Byte-operand address for the word now on the fetch port.
   always_comb begin
      if (fetch_word[8]) begin
         eff_addr = {bsr_reg[3:0], fetch_word[7:0]};
      end else if (fetch_word[7:0] <= `CID_ACCESS_LIMIT) begin
         if (ext_reg) begin
            eff_addr = ptr_reg[2] + {4'h0, fetch_word[7:0]};
         end else begin
            eff_addr = {4'h0, fetch_word[7:0]};
         end
      end else begin
         eff_addr = {`CID_ACCESS_HIGH, fetch_word[7:0]};
      end
   end

   // Opcodes outside this subset decode to a no-operation cycle.
   always_comb begin
      if (fetch_word[15:10] == `CID_OP6_INC) begin
         dec_op = cid_pkg::CID_INC;
      end else if (fetch_word[15:10] == `CID_OP6_COPY_FILE_REGISTER) begin
         dec_op = cid_pkg::CID_COPY_FILE_REGISTER;
      end else if (fetch_word[15:8] == `CID_OP8_IOR) begin
         dec_op = cid_pkg::CID_IOR;
      end else if (fetch_word[15:8] == `CID_OP8_LOAD_ACCUMULATOR_LITERAL) begin
         dec_op = cid_pkg::CID_LOAD_ACCUMULATOR_LITERAL;
      end else if (fetch_word[15:8] == `CID_OP8_LOAD_BANK_LITERAL) begin
         dec_op = cid_pkg::CID_LOAD_BANK_LITERAL;
      end else if (fetch_word[15:6] == `CID_OP10_LOAD_POINTER_LITERAL) begin
         dec_op = cid_pkg::CID_LOAD_POINTER_LITERAL;
      end else if (fetch_word[15:12] == `CID_OP4_COPY_FILE_TO_FILE) begin
         dec_op = cid_pkg::CID_COPY_FILE_TO_FILE;
      end else begin
         dec_op = cid_pkg::CID_NOP;
      end
   end

   always_comb begin
      case (op_reg)
         cid_pkg::CID_INC: res_next = operand + 8'h01;
         cid_pkg::CID_IOR: res_next = w_reg | ir_reg[7:0];
         cid_pkg::CID_COPY_FILE_REGISTER: res_next = operand;
         cid_pkg::CID_COPY_FILE_TO_FILE: res_next = second_reg ? hold_reg : operand;
         default: res_next = ir_reg[7:0];
      endcase
   end

   // Four phases per instruction cycle; Q1 waits for a fetched word.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_reg <= cid_pkg::CID_Q1;
      end else begin
         case (phase_reg)
            cid_pkg::CID_Q1: begin
               if (take) begin
                  phase_reg <= cid_pkg::CID_Q2;
               end
            end
            cid_pkg::CID_Q2: phase_reg <= cid_pkg::CID_Q3;
            cid_pkg::CID_Q3: phase_reg <= cid_pkg::CID_Q4;
            cid_pkg::CID_Q4: phase_reg <= cid_pkg::CID_Q1;
            default: phase_reg <= cid_pkg::CID_Q1;
         endcase
      end
   end

   // Halting only stops the next word from being taken, never a cycle midway.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fetch_ready <= 1'b0;
      end else begin
         fetch_ready <= !halt_reg && ((phase_reg == cid_pkg::CID_Q4) ||
                        (phase_reg == cid_pkg::CID_Q1 && !take));
      end
   end

   // Decode of the taken word, including skip and second-word handling.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         op_reg <= cid_pkg::CID_NOP;
         ir_reg <= 16'h0000;
         lo_reg <= 16'h0000;
         src_w_reg <= 1'b0;
         dest_w_reg <= 1'b0;
      end else if (take) begin
         if (second_reg) begin
            lo_reg <= fetch_word;
            dest_w_reg <= (fetch_word[11:0] == `CID_WREG_ADDR);
         end else if (skip_reg) begin
            op_reg <= cid_pkg::CID_NOP;
            src_w_reg <= 1'b0;
         end else begin
            op_reg <= dec_op;
            ir_reg <= fetch_word;
            src_w_reg <= (dec_op == cid_pkg::CID_COPY_FILE_TO_FILE) &&
                         (fetch_word[11:0] == `CID_WREG_ADDR);
         end
      end
   end

   // Second-cycle and skip bookkeeping, settled at the end of Q4 and when a skipped word is taken.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         second_reg <= 1'b0;
         skip_reg <= 1'b0;
      end else if (take && skip_reg && !second_reg) begin
         skip_reg <= two_word(fetch_word);
      end else if (phase_reg == cid_pkg::CID_Q4) begin
         if (second_reg) begin
            second_reg <= 1'b0;
         end else if (op_reg == cid_pkg::CID_LOAD_POINTER_LITERAL ||
                      op_reg == cid_pkg::CID_COPY_FILE_TO_FILE) begin
            second_reg <= 1'b1;
         end
         if (op_reg == cid_pkg::CID_INC && res_reg != 8'h00) begin
            skip_reg <= 1'b1;
         end
      end
   end

   // Data memory port: read strobe in Q2, write strobe in Q4.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mem_addr <= 12'h000;
         mem_rd_en <= 1'b0;
      end else if (take && second_reg) begin
         mem_addr <= fetch_word[11:0];
         mem_rd_en <= 1'b0;
      end else if (take && !skip_reg) begin
         if (dec_op == cid_pkg::CID_COPY_FILE_TO_FILE) begin
            mem_addr <= fetch_word[11:0];
            mem_rd_en <= (fetch_word[11:0] != `CID_WREG_ADDR);
         end else begin
            mem_addr <= eff_addr;
            mem_rd_en <= (dec_op == cid_pkg::CID_INC ||
                          dec_op == cid_pkg::CID_COPY_FILE_REGISTER);
         end
      end else begin
         mem_rd_en <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mem_wr_en <= 1'b0;
         mem_wdata <= 8'h00;
      end else if (phase_reg == cid_pkg::CID_Q3) begin
         mem_wdata <= res_next;
         if (op_reg == cid_pkg::CID_INC || op_reg == cid_pkg::CID_COPY_FILE_REGISTER) begin
            mem_wr_en <= ir_reg[9];
         end else begin
            mem_wr_en <= op_reg == cid_pkg::CID_COPY_FILE_TO_FILE && second_reg &&
                         !dest_w_reg;
         end
      end else begin
         mem_wr_en <= 1'b0;
      end
   end

   // Operand processing in Q3.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         res_reg <= 8'h00;
         hold_reg <= 8'h00;
      end else if (phase_reg == cid_pkg::CID_Q3) begin
         res_reg <= res_next;
         if (op_reg == cid_pkg::CID_COPY_FILE_TO_FILE && !second_reg) begin
            hold_reg <= operand;
         end
      end
   end

   // Accumulator write-back in Q4.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         w_reg <= `CID_W_RST;
      end else if (phase_reg == cid_pkg::CID_Q4) begin
         case (op_reg)
            cid_pkg::CID_INC,
            cid_pkg::CID_COPY_FILE_REGISTER: begin
               if (!ir_reg[9]) begin
                  w_reg <= res_reg;
               end
            end
            cid_pkg::CID_IOR,
            cid_pkg::CID_LOAD_ACCUMULATOR_LITERAL: w_reg <= res_reg;
            cid_pkg::CID_COPY_FILE_TO_FILE: begin
               if (second_reg && dest_w_reg) begin
                  w_reg <= res_reg;
               end
            end
            default: w_reg <= w_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         neg_reg <= 1'b0;
         zero_reg <= 1'b0;
      end else if (phase_reg == cid_pkg::CID_Q4 &&
                   (op_reg == cid_pkg::CID_IOR ||
                    op_reg == cid_pkg::CID_COPY_FILE_REGISTER)) begin
         neg_reg <= res_reg[7];
         zero_reg <= (res_reg == 8'h00);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bsr_reg <= `CID_BSR_RST;
      end else if (phase_reg == cid_pkg::CID_Q4 &&
                   op_reg == cid_pkg::CID_LOAD_BANK_LITERAL) begin
         bsr_reg <= {4'h0, res_reg[3:0]};
      end
   end

   // Pointer select 3 is not a pointer, so such a load writes nothing.
   for (genvar p = 0; p < `CID_PTR_COUNT; p++) begin : g_ptr
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            ptr_reg[p] <= `CID_PTR_RST;
         end else if (phase_reg == cid_pkg::CID_Q4 &&
                      op_reg == cid_pkg::CID_LOAD_POINTER_LITERAL &&
                      ir_reg[5:4] == 2'(p)) begin
            if (second_reg) begin
               ptr_reg[p][7:0] <= lo_reg[7:0];
            end else begin
               ptr_reg[p][11:8] <= ir_reg[3:0];
            end
         end
      end
   end

   // AXI4-Lite write side: address and data caught in either order.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CID_RESP_OKAY;
         ext_reg <= `CID_CTRL_EXT_RST;
         halt_reg <= `CID_CTRL_HALT_RST;
      end else begin
         s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            if ((aw_addr_reg >> 6) != '0) begin
               s_axi_bresp <= `CID_RESP_SLVERR;
            end else begin
               case (aw_addr_reg[5:0])
                  `CID_OFS_CTRL: begin
                     s_axi_bresp <= `CID_RESP_OKAY;
                     if (w_strb_reg[0]) begin
                        ext_reg <= w_data_reg[`CID_CTRL_EXT_BIT];
                        halt_reg <= w_data_reg[`CID_CTRL_HALT_BIT];
                     end
                  end
                  `CID_OFS_W, `CID_OFS_BSR, `CID_OFS_STATUS,
                  `CID_OFS_PTR0, `CID_OFS_PTR1, `CID_OFS_PTR2:
                     s_axi_bresp <= `CID_RESP_OKAY;
                  default: s_axi_bresp <= `CID_RESP_SLVERR;
               endcase
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_hit = ((s_axi_araddr >> 6) == '0);
      case (s_axi_araddr[5:0])
         `CID_OFS_CTRL: rd_mux = {30'h0, halt_reg, ext_reg};
         `CID_OFS_W: rd_mux = {24'h0, w_reg};
         `CID_OFS_BSR: rd_mux = {24'h0, bsr_reg};
         `CID_OFS_STATUS: rd_mux = {26'h0, neg_reg, zero_reg, skip_reg,
                                   second_reg, phase_reg};
         `CID_OFS_PTR0: rd_mux = {20'h0, ptr_reg[0]};
         `CID_OFS_PTR1: rd_mux = {20'h0, ptr_reg[1]};
         `CID_OFS_PTR2: rd_mux = {20'h0, ptr_reg[2]};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // AXI4-Lite read side: one read in flight, answered the next cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CID_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_hit ? rd_mux : 32'h0000_0000;
         s_axi_rresp <= rd_hit ? `CID_RESP_OKAY : `CID_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // cid_core
`default_nettype wire

// >>> rtl/cid_defines.svh
// Offsets, field positions, opcodes and reset values of the decode core.
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_OFS_CTRL 6'h00
`define CID_OFS_W 6'h04
`define CID_OFS_BSR 6'h08
`define CID_OFS_STATUS 6'h0c
`define CID_OFS_PTR0 6'h10
`define CID_OFS_PTR1 6'h14
`define CID_OFS_PTR2 6'h18
`define CID_CTRL_EXT_BIT 0
`define CID_CTRL_HALT_BIT 1
`define CID_CTRL_EXT_RST 1'b0
`define CID_CTRL_HALT_RST 1'b0
`define CID_W_RST 8'h00
`define CID_BSR_RST 8'h00
`define CID_PTR_RST 12'h000
`define CID_RESP_OKAY 2'b00
`define CID_RESP_SLVERR 2'b10
`define CID_OP6_INC 6'h12
`define CID_OP6_COPY_FILE_REGISTER 6'h14
`define CID_OP8_IOR 8'h09
`define CID_OP8_LOAD_ACCUMULATOR_LITERAL 8'h0e
`define CID_OP8_LOAD_BANK_LITERAL 8'h01
`define CID_OP10_LOAD_POINTER_LITERAL 10'h3b8
`define CID_OP4_COPY_FILE_TO_FILE 4'hc
`define CID_OP6_TWO_WORD 6'h3b
`define CID_ACCESS_LIMIT 8'h5f
`define CID_ACCESS_HIGH 4'hf
`define CID_WREG_ADDR 12'hfe8
`define CID_PTR_COUNT 3
`endif

// >>> rtl/cid_pkg.sv
// Types shared by the decode core: phase and operation codes.
`default_nettype none
package cid_pkg;
   typedef enum logic [1:0] {
      CID_Q1 = 2'b00,
      CID_Q2 = 2'b01,
      CID_Q3 = 2'b11,
      CID_Q4 = 2'b10
   } cid_phase_e;
   typedef enum logic [2:0] {
      CID_NOP = 3'h0,
      CID_INC = 3'h1,
      CID_IOR = 3'h2,
      CID_LOAD_POINTER_LITERAL = 3'h3,
      CID_COPY_FILE_REGISTER = 3'h4,
      CID_COPY_FILE_TO_FILE = 3'h5,
      CID_LOAD_BANK_LITERAL = 3'h6,
      CID_LOAD_ACCUMULATOR_LITERAL = 3'h7
   } cid_op_e;
endpackage
`default_nettype wire

// >>> test/cid_mem_model.sv
// Data memory model with a registered read of one cycle latency.
`timescale 1ns/1ps
`default_nettype none
module cid_mem_model (
   input wire logic ref_clk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd_en,
   output logic [7:0] mem_rdata,
   input wire logic mem_wr_en,
   input wire logic [7:0] mem_wdata
);
   logic [7:0] mem [0:4095];
   initial mem_rdata = 8'h00;
   // Outside a read cycle the data turns over each clock, so a late sample
   // never picks up the previous byte by luck.
   always @(posedge ref_clk) begin
      if (mem_rd_en)
         mem_rdata <= mem[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_wr_en)
         mem[mem_addr] <= mem_wdata;
   end
endmodule // cid_mem_model
`default_nettype wire

// >>> test/cid_core_chk.sv
// Checker for fetch, memory and register-bus timing of the decode core.
`timescale 1ns/1ps
`default_nettype none
module cid_core_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic fetch_valid,
   input wire logic fetch_ready,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic take;
   assign take = fetch_valid && fetch_ready;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   take_gap_a: assert property (take |=> !fetch_ready [*3])
      else $error("fetch ready returned within the cycle");
   read_phase_a: assert property (mem_rd_en |-> $past(take))
      else $error("memory read outside the operand read phase");
   write_phase_a: assert property (mem_wr_en |-> $past(take, 3))
      else $error("memory write outside the write-back phase");
   read_pulse_a: assert property (mem_rd_en |=>
      !mem_rd_en && !mem_wr_en)
      else $error("read pulse too long or write too early");
   same_addr_a: assert property (mem_rd_en ##2 mem_wr_en |->
      mem_addr == $past(mem_addr, 2))
      else $error("write-back address differs from read address");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");
   b_block_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("new write accepted during a response");
endmodule // cid_core_chk
bind cid_core cid_core_chk i_chk (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the decode core and its data memory.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] fetch_word = 16'h0000;
   logic fetch_valid = 1'b0;
   logic fetch_ready, mem_rd_en, mem_wr_en, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] mem_addr;
   logic [7:0] mem_rdata, mem_wdata;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] rdat;
   int errors = 0;
   int checks_done = 0;
   cid_core i_dut (.*);
   cid_mem_model i_mem (.*);
   initial forever #50 ref_clk = ~ref_clk;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wt(inout int n);
      @(posedge ref_clk);
      n++;
      if (n > 100) begin
         chk("handshake timeout", 32'h0, 32'h1);
         finish_test();
      end
   endtask
   task automatic fetch(input logic [15:0] w);
      int n;
      n = 0;
      fetch_word <= w;
      fetch_valid <= 1'b1;
      do wt(n); while (fetch_ready !== 1'b1);
   endtask
   // The trailing filler word is only taken once the last real one is done.
   task automatic run(input logic [15:0] q[$]);
      @(posedge ref_clk);
      foreach (q[i]) fetch(q[i]);
      fetch(16'h0000);
      fetch_valid <= 1'b0;
   endtask
   task automatic axw(input logic [5:0] a, input logic [31:0] d);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         wt(n);
         aw = aw && s_axi_awready !== 1'b1;
         w = w && s_axi_wready !== 1'b1;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      // The response is left waiting once, so it must stand until taken.
      do wt(n); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      do wt(n); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [5:0] a,
                       input logic [31:0] exp, input logic [31:0] m);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do wt(n); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do wt(n); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      do wt(n); while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(nm, rdat & m, exp);
   endtask
   task automatic t_regs;
      rchk("ctrl", 6'h00, 32'h0, 32'hffffffff);
      rchk("w reset", 6'h04, 32'h0, 32'hff);
      rchk("unmapped", 6'h1c, 32'h0, 32'hffffffff);
      chk("unmapped resp", rsp, 32'h2);
      axw(6'h04, 32'hff);
      chk("ro write resp", rsp, 32'h0);
      axw(6'h1c, 32'h1);
      chk("unmapped wr resp", rsp, 32'h2);
      rchk("w kept", 6'h04, 32'h0, 32'hff);
      $display("done registers");
   endtask
   task automatic t_lit;
      run({16'h0e9a});
      rchk("w", 6'h04, 32'h9a, 32'hff);
      rchk("nz", 6'h0c, 32'h00, 32'h30);
      run({16'h0935});
      rchk("w", 6'h04, 32'hbf, 32'hff);
      rchk("nz", 6'h0c, 32'h20, 32'h30);
      run({16'h0e00, 16'h0900});
      rchk("nz", 6'h0c, 32'h10, 32'h30);
      run({16'h0e80, 16'h01f5});
      rchk("nz", 6'h0c, 32'h10, 32'h30);
      rchk("bank", 6'h08, 32'h05, 32'hff);
      $display("done literals");
   endtask
   task automatic t_inc;
      i_mem.mem[12'h520] = 8'h41;
      i_mem.mem[12'hf60] = 8'hff;
      run({16'h4b20, 16'h0e11});
      chk("m520", i_mem.mem[12'h520], 32'h42);
      rchk("w", 6'h04, 32'h80, 32'hff);
      rchk("nz", 6'h0c, 32'h10, 32'h30);
      run({16'h4860, 16'h093c});
      rchk("w", 6'h04, 32'h3c, 32'hff);
      chk("mf60", i_mem.mem[12'hf60], 32'hff);
      i_mem.mem[12'h010] = 8'h00;
      i_mem.mem[12'h011] = 8'hff;
      run({16'h4a10, 16'hee13, 16'h0e77});
      rchk("w", 6'h04, 32'h3c, 32'hff);
      rchk("ptr1", 6'h14, 32'h0, 32'hfff);
      run({16'h4a11, 16'hee23, 16'h00ab});
      rchk("ptr2", 6'h18, 32'h3ab, 32'hfff);
      $display("done increment");
   endtask
   task automatic t_ext;
      i_mem.mem[12'h3b0] = 8'h80;
      i_mem.mem[12'h005] = 8'h11;
      axw(6'h00, 32'h1);
      run({16'h5005});
      rchk("w", 6'h04, 32'h80, 32'hff);
      rchk("nz", 6'h0c, 32'h20, 32'h30);
      axw(6'h00, 32'h0);
      run({16'h5005});
      rchk("w", 6'h04, 32'h11, 32'hff);
      $display("done indexed");
   endtask
   task automatic t_move;
      i_mem.mem[12'h123] = 8'h33;
      // Destinations stay clear of the counter and return-top bytes.
      run({16'hc123, 16'hf456, 16'hcfe8, 16'hf700});
      chk("m456", i_mem.mem[12'h456], 32'h33);
      chk("m700", i_mem.mem[12'h700], 32'h11);
      run({16'hc123, 16'hffe8});
      rchk("w", 6'h04, 32'h33, 32'hff);
      rchk("nz", 6'h0c, 32'h00, 32'h30);
      // Pointer select 3 names no pointer, so all three keep their values.
      run({16'hee35, 16'h0012});
      rchk("ptr0", 6'h10, 32'h0, 32'hfff);
      rchk("ptr2 kept", 6'h18, 32'h3ab, 32'hfff);
      $display("done file move");
   endtask
   task automatic t_halt;
      axw(6'h00, 32'h2);
      rchk("halt set", 6'h00, 32'h2, 32'h3);
      fetch_word <= 16'h0e5a;
      fetch_valid <= 1'b1;
      repeat (8) begin
         @(posedge ref_clk);
         chk("ready halted", fetch_ready, 32'h0);
      end
      fetch_valid <= 1'b0;
      axw(6'h00, 32'h0);
      rchk("w halted", 6'h04, 32'h33, 32'hff);
      $display("done halt");
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      t_lit();
      t_inc();
      t_ext();
      t_move();
      t_halt();
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
